// *** stepper_brake_status_monitor.sv ***
// brake control, angle tracking and open-drain status flags
//
// Our own choices: the address map and the strobed register port.
module stepper_brake_status_monitor
	import stepper_brake_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// control pins from the host
	input wire logic i_brake,
	input wire logic i_step_clk,
	input wire logic i_rotation_dir,
	input wire logic i_step_res_sel0,
	input wire logic i_step_res_sel1,
	input wire logic i_step_res_sel2,
	// analog comparator results
	input wire logic i_vref_tied_high,
	input wire logic i_thermal_shutdown_event,
	input wire logic i_overcurrent_shutdown_event,
	input wire logic i_temp_warn_detect,
	input wire logic i_temp_below_release,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_irq,
	// output stage
	output drive_t o_drive,
	output logic o_full_scale,
	output logic [ANGLE_W-1:0] o_angle,
	// open-drain flags
	output logic o_home_angle_flag_n_out,
	output logic o_home_angle_flag_n_oe,
	output logic o_fault_flag_n_out,
	output logic o_fault_flag_n_oe,
	output logic o_thermal_warn_n_out,
	output logic o_thermal_warn_n_oe
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	localparam int SYN_W = 11;
	logic [SYN_W-1:0] syn1_r;
	logic [SYN_W-1:0] syn2_r;
	logic step_d_r;
	logic brake_s, step_s, dir_s, cc_off_s, tsd_s, isd_s, wdet_s, wrel_s;
	logic [2:0] sel_s;
	// first stage is read only by the second
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			syn1_r <= '0;
			syn2_r <= '0;
			step_d_r <= 1'b0;
		end else begin
			syn1_r <= {i_brake, i_step_clk, i_rotation_dir, i_step_res_sel2,
				i_step_res_sel1, i_step_res_sel0, i_vref_tied_high,
				i_thermal_shutdown_event, i_overcurrent_shutdown_event,
				i_temp_warn_detect, i_temp_below_release};
			syn2_r <= syn1_r;
			step_d_r <= syn2_r[9];
		end
	end
	assign {brake_s, step_s, dir_s, sel_s, cc_off_s, tsd_s, isd_s, wdet_s, wrel_s} = syn2_r;
	// ************************************************************
	// core state
	// ************************************************************
	mode_t mode_r, mode_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [ANGLE_W-1:0] angle_r, angle_nxt, angle_adv, home_r;
	logic brake_r, brake_nxt, held_a_r, held_a_nxt, held_b_r, held_b_nxt;
	logic fault_r, fault_nxt, warn_r, warn_nxt, home_hit_nxt;
	logic step_rise;
	drive_t drive_r, drive_nxt;
	assign step_rise = step_s & ~step_d_r;
	// wraps modulo one turn, the carry is dropped on purpose
	assign angle_adv = dir_s ? ANGLE_W'(angle_r + step_incr(sel_s))
		: ANGLE_W'(angle_r - step_incr(sel_s));
	// next-state of mode, angle, brake and flags
	always_comb begin
		mode_nxt = mode_r;
		cnt_nxt = cnt_r;
		angle_nxt = angle_r;
		brake_nxt = brake_s;
		held_a_nxt = held_a_r;
		held_b_nxt = held_b_r;
		// set wins: an event during standby still latches
		fault_nxt = (fault_r & (mode_r != MODE_LOW_POWER_SELECT)) | tsd_s | isd_s;
		// hysteresis: hold until below release and detect gone
		warn_nxt = wdet_s | (warn_r & ~wrel_s);
		unique case (mode_r)
			MODE_LOW_POWER_SELECT: begin
				angle_nxt = home_r;
				if (sel_s != SEL_STANDBY) begin
					mode_nxt = MODE_START;
					cnt_nxt = CNT_W'(STARTUP_CYC - 1);
				end
			end
			MODE_START: begin
				// inputs are not trusted while the bias settles
				if (cnt_r == '0) begin
					mode_nxt = MODE_RUN;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			MODE_RUN: begin
				if (step_rise) begin
					angle_nxt = angle_adv;
				end
			end
			default: mode_nxt = MODE_LOW_POWER_SELECT;
		endcase
		if (sel_s == SEL_STANDBY) begin
			mode_nxt = MODE_LOW_POWER_SELECT;
		end
		// capture winding polarity on the brake edge
		if (brake_s && !brake_r) begin
			held_a_nxt = pol_a(angle_r);
			held_b_nxt = pol_b(angle_r);
		end
		home_hit_nxt = angle_r == home_r;
		// output stage off in standby, startup or fault
		if (mode_r != MODE_RUN || fault_r) begin
			drive_nxt = DRIVE_OFF;
		end else if (brake_r && cc_off_s) begin
			drive_nxt = DRIVE_ALL;
		end else if (brake_r) begin
			// reference at or below threshold: polarity hold
			drive_nxt = {held_a_r, ~held_a_r, held_b_r, ~held_b_r};
		end else begin
			drive_nxt = {pol_a(angle_r), ~pol_a(angle_r), pol_b(angle_r), ~pol_b(angle_r)};
		end
	end
	// core registers
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_r <= MODE_LOW_POWER_SELECT;
			cnt_r <= '0;
			angle_r <= HOME_RST;
			brake_r <= 1'b0;
			held_a_r <= 1'b0;
			held_b_r <= 1'b0;
			fault_r <= 1'b0;
			warn_r <= 1'b0;
			drive_r <= DRIVE_OFF;
			o_home_angle_flag_n_oe <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			cnt_r <= cnt_nxt;
			angle_r <= angle_nxt;
			brake_r <= brake_nxt;
			held_a_r <= held_a_nxt;
			held_b_r <= held_b_nxt;
			fault_r <= fault_nxt;
			warn_r <= warn_nxt;
			drive_r <= drive_nxt;
			o_home_angle_flag_n_oe <= home_hit_nxt;
		end
	end
	// flag pins only ever pull low
	assign o_home_angle_flag_n_out = 1'b0;
	assign o_fault_flag_n_out = 1'b0;
	assign o_thermal_warn_n_out = 1'b0;
	assign o_fault_flag_n_oe = fault_r;
	assign o_thermal_warn_n_oe = warn_r;
	assign o_full_scale = brake_r;
	assign o_drive = drive_r;
	assign o_angle = angle_r;
	// ************************************************************
	// register port and interrupts
	// ************************************************************
	logic [IRQ_W-1:0] stat_r, stat_nxt, en_r, en_nxt, clr;
	logic [ANGLE_W-1:0] home_nxt;
	logic [DATA_W-1:0] rdata_nxt;
	logic irq_nxt, home_seen_r;
	logic [15:0] state_word;
	assign state_word = {mode_r == MODE_START, cc_off_s, held_b_r, held_a_r, warn_r,
		fault_r, mode_r == MODE_LOW_POWER_SELECT, brake_r, 1'b0, angle_r};
	// bus decode, sticky status with set over clear
	always_comb begin
		clr = '0;
		en_nxt = en_r;
		home_nxt = home_r;
		rdata_nxt = '0;
		if (i_wr) begin
			unique case (i_addr)
				OFS_IRQ_CLR: clr = i_wdata[IRQ_W-1:0];
				OFS_IRQ_EN: en_nxt = i_wdata[IRQ_W-1:0];
				OFS_HOME: home_nxt = i_wdata[ANGLE_W-1:0];
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				OFS_STATUS: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, stat_r};
				OFS_IRQ_EN: rdata_nxt = {{(DATA_W-IRQ_W){1'b0}}, en_r};
				OFS_STATE: rdata_nxt = {16'h0000, state_word};
				OFS_HOME: rdata_nxt = {{(DATA_W-ANGLE_W){1'b0}}, home_r};
				default: rdata_nxt = '0;
			endcase
		end
		stat_nxt = stat_r & ~clr;
		stat_nxt[IRQ_FAULT] = stat_nxt[IRQ_FAULT] | (fault_nxt & ~fault_r);
		stat_nxt[IRQ_WARN] = stat_nxt[IRQ_WARN] | (warn_nxt & ~warn_r);
		stat_nxt[IRQ_HOME] = stat_nxt[IRQ_HOME] | (home_hit_nxt & ~home_seen_r);
		irq_nxt = |(stat_nxt & en_nxt);
	end
	// bus registers
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stat_r <= '0;
			en_r <= IRQ_EN_RST;
			home_r <= HOME_RST;
			o_rdata <= '0;
			o_irq <= 1'b0;
			home_seen_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			en_r <= en_nxt;
			home_r <= home_nxt;
			o_rdata <= rdata_nxt;
			o_irq <= irq_nxt;
			home_seen_r <= home_hit_nxt;
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_shutdown;
		tsd_s || isd_s;
	endsequence
	sequence s_latched_off;
		fault_r ##1 (drive_r == DRIVE_OFF);
	endsequence
	a_brake_follows: assert property (brake_s != brake_r |=> brake_r == $past(brake_s))
		else $error("brake not taken next cycle");
	a_hold_polarity: assert property ($rose(brake_r) |-> held_a_r == pol_a($past(angle_r))
		&& held_b_r == pol_b($past(angle_r)))
		else $error("brake polarity not captured");
	a_brake_drive: assert property (brake_r && !cc_off_s && mode_r == MODE_RUN && !fault_r
		|=> drive_r == {$past(held_a_r), ~$past(held_a_r), $past(held_b_r), ~$past(held_b_r)})
		else $error("brake drive wrong");
	a_all_on: assert property (brake_r && cc_off_s && mode_r == MODE_RUN && !fault_r
		|=> drive_r == DRIVE_ALL)
		else $error("all transistors not on");
	a_step_in_brake: assert property (mode_r == MODE_RUN && step_rise && sel_s != SEL_STANDBY
		|=> angle_r == $past(angle_adv))
		else $error("step edge did not advance");
	a_home_flag: assert property (1'b1 |=> o_home_angle_flag_n_oe == ($past(angle_r) == $past(home_r)))
		else $error("home flag mismatch");
	a_fault_latch: assert property (s_shutdown |=> s_latched_off)
		else $error("shutdown not latched off");
	a_fault_clear: assert property ($fell(fault_r) |-> $past(mode_r) == MODE_LOW_POWER_SELECT)
		else $error("fault cleared outside standby");
	a_warn_self: assert property ($fell(warn_r) |-> $past(wrel_s) && !$past(wdet_s))
		else $error("warning released early");
	a_warn_set: assert property (wdet_s && !fault_r && mode_r == MODE_RUN
		&& sel_s != SEL_STANDBY |=> warn_r && mode_r == MODE_RUN)
		else $error("warning not set");
	a_standby_entry: assert property (sel_s == SEL_STANDBY |=> mode_r == MODE_LOW_POWER_SELECT
		##1 drive_r == DRIVE_OFF)
		else $error("standby not entered");
	a_startup_hold: assert property ($rose(mode_r == MODE_START) && sel_s != SEL_STANDBY
		|-> ##1 (mode_r != MODE_RUN) [*8])
		else $error("startup too short");
	a_od_low_only: assert property (!o_fault_flag_n_out && !o_thermal_warn_n_out
		&& !o_home_angle_flag_n_out)
		else $error("open drain driven high");
	// brake holds its captured polarity until released
	a_held_stable: assert property (brake_r && $past(brake_r)
		|-> $stable(held_a_r) && $stable(held_b_r))
		else $error("held polarity changed in brake");
	a_full_scale: assert property (brake_s |=> o_full_scale)
		else $error("ratio not forced full scale");
	// normal drive follows the phase polarity of the angle
	a_run_drive: assert property (!brake_r && !fault_r && mode_r == MODE_RUN
		|=> drive_r == {pol_a($past(angle_r)), ~pol_a($past(angle_r)),
		pol_b($past(angle_r)), ~pol_b($past(angle_r))})
		else $error("normal drive wrong");
	// flag pins follow their latches one cycle after the synced event
	a_fault_pin: assert property (s_shutdown |=> o_fault_flag_n_oe)
		else $error("fault pin not pulled low");
	a_warn_pin: assert property (wdet_s |=> o_thermal_warn_n_oe)
		else $error("warning pin not pulled low");
	a_warn_hold: assert property (warn_r && !wrel_s |=> warn_r)
		else $error("warning released above release level");
	// angle parked at home in standby, frozen during startup
	a_standby_home: assert property (mode_r == MODE_LOW_POWER_SELECT |=> angle_r == $past(home_r))
		else $error("angle not parked at home");
	a_startup_still: assert property (mode_r == MODE_START |=> angle_r == $past(angle_r))
		else $error("angle moved during startup");
	a_startup_count: assert property (mode_r == MODE_START
		|-> cnt_r < CNT_W'(STARTUP_CYC))
		else $error("startup counter out of range");
	// bus side: sticky status, interrupt level, idle read data
	a_status_set: assert property ($rose(fault_r) |-> stat_r[IRQ_FAULT])
		else $error("fault status lost to clear");
	a_irq_level: assert property (o_irq == |(stat_r & en_r))
		else $error("interrupt level wrong");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
		else $error("read data not idle");
endmodule : stepper_brake_status_monitor

// *** stepper_brake_pkg.sv ***
// constants, types and helpers of the brake and status monitor
// Contract
// - brake high enters brake, low leaves
// - constant-current brake holds phase polarity, full current
// - brake forces current ratio full scale
// - step edges advance angle during brake
// - low reference means constant-current mode
// - current control off: brake turns all on
// - home flag low exactly at initial angle
// - flags only pull low or release
// - fault flag low after shutdown event
// - fault cleared only by standby or power
// - warning low at detect, outputs keep running
// - warning self-clears below release threshold
// - all selects low: standby, off, latches cleared (code clears the fault latch only, not the warning)
// - shutdown turns outputs off until cleared
package stepper_brake_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h04;
	localparam logic [4:0] OFS_IRQ_EN = 5'h08;
	localparam logic [4:0] OFS_STATE = 5'h0C;
	localparam logic [4:0] OFS_HOME = 5'h10;
	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_WARN = 1;
	localparam int IRQ_HOME = 2;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	// state register fields
	localparam int ST_ANGLE = 0;
	localparam int ST_BRAKE = 8;
	localparam int ST_STANDBY = 9;
	localparam int ST_FAULT = 10;
	localparam int ST_WARN = 11;
	localparam int ST_HELD_A = 12;
	localparam int ST_HELD_B = 13;
	localparam int ST_CC_OFF = 14;
	localparam int ST_STARTUP = 15;
	// ************************************************************
	// angle and timing
	// ************************************************************
	localparam int ANGLE_W = 7;
	localparam logic [6:0] HOME_RST = 7'h00;
	localparam int CLK_NS = 10;
	localparam int STARTUP_NS = 10000;
	localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = $clog2(STARTUP_CYC + 1);
	localparam logic [2:0] SEL_STANDBY = 3'h0;
	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic a_pos;
		logic a_neg;
		logic b_pos;
		logic b_neg;
	} drive_t;
	localparam drive_t DRIVE_OFF = 4'h0;
	localparam drive_t DRIVE_ALL = 4'hF;
	typedef enum logic [2:0] {
		MODE_LOW_POWER_SELECT = 3'b001,
		MODE_START = 3'b010,
		MODE_RUN = 3'b100
	} mode_t;
	// microsteps of the 1/32 grid moved per step edge
	function automatic logic [6:0] step_incr(input logic [2:0] sel);
		logic [6:0] r;
		r = 7'h00;
		unique case (sel)
			3'h1: r = 7'h20;
			3'h2: r = 7'h10;
			3'h3: r = 7'h08;
			3'h4: r = 7'h10;
			3'h5: r = 7'h04;
			3'h6: r = 7'h02;
			3'h7: r = 7'h01;
			default: r = 7'h00;
		endcase
		return r;
	endfunction : step_incr
	// phase a follows cosine, positive in first and last quadrant
	function automatic logic pol_a(input logic [6:0] ang);
		return ang[6] == ang[5];
	endfunction : pol_a
	// phase b follows sine, positive in the first half turn
	function automatic logic pol_b(input logic [6:0] ang);
		return ~ang[6];
	endfunction : pol_b
endpackage : stepper_brake_pkg

// *** host_pin_model.sv ***
// host controller model driving brake, step clock and mode pins
module host_pin_model
	import stepper_brake_pkg::*;
(
	// clock
	input wire logic i_sys_clk,
	// pins toward the device
	output logic o_brake,
	output logic o_step_clk,
	output logic o_rotation_dir,
	output logic [2:0] o_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// pin sequences
	// ************************************************************
	// power-up pin levels: standby, no brake, counting up
	initial begin
		o_brake = 1'b0;
		o_step_clk = 1'b0;
		o_rotation_dir = 1'b1;
		o_sel = SEL_STANDBY;
	end
	// brake is a plain level, held until told otherwise
	task automatic set_brake(input logic b);
		@(posedge i_sys_clk);
		o_brake <= b;
		repeat (6) @(posedge i_sys_clk);
		#1;
	endtask : set_brake
	// pulses wide enough to survive the two-flop sync
	task automatic step(input int n);
		repeat (n) begin
			@(posedge i_sys_clk);
			o_step_clk <= 1'b1;
			repeat (4) @(posedge i_sys_clk);
			o_step_clk <= 1'b0;
			repeat (3) @(posedge i_sys_clk);
		end
		repeat (4) @(posedge i_sys_clk);
		#1;
	endtask : step
	// mode change; pins stay quiet through the startup window
	task automatic set_sel(input logic [2:0] s);
		@(posedge i_sys_clk);
		o_sel <= s;
		repeat (STARTUP_CYC + 8) @(posedge i_sys_clk);
		#1;
	endtask : set_sel
	// direction is a level; let it pass the sync before stepping
	task automatic set_dir(input logic d);
		@(posedge i_sys_clk);
		o_rotation_dir <= d;
		repeat (4) @(posedge i_sys_clk);
		#1;
	endtask : set_dir
endmodule : host_pin_model

// *** testbench.sv ***
// self-checking bench of the brake and status monitor
module testbench
	import stepper_brake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic clk = 1'b0;
	logic resetn, vref, thermal_shutdown_event, overcurrent_shutdown_event, wdet, wrel, wr, rd;
	logic brake, stepc, dir, irq, fs, ho, hoe, fo, foe, wo, woe;
	logic [2:0] sel;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic [6:0] angle;
	drive_t drive;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// free-running 100 MHz clock
	always #5 clk = ~clk;
	host_pin_model host_pin_model_inst (.i_sys_clk(clk), .o_brake(brake), .o_step_clk(stepc),
		.o_rotation_dir(dir), .o_sel(sel));
	stepper_brake_status_monitor stepper_brake_status_monitor_inst (.i_sys_clk(clk),
		.i_resetn(resetn), .i_brake(brake), .i_step_clk(stepc), .i_rotation_dir(dir),
		.i_step_res_sel0(sel[0]), .i_step_res_sel1(sel[1]), .i_step_res_sel2(sel[2]),
		.i_vref_tied_high(vref), .i_thermal_shutdown_event(thermal_shutdown_event),
		.i_overcurrent_shutdown_event(overcurrent_shutdown_event), .i_temp_warn_detect(wdet),
		.i_temp_below_release(wrel), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_irq(irq), .o_drive(drive), .o_full_scale(fs), .o_angle(angle),
		.o_home_angle_flag_n_out(ho), .o_home_angle_flag_n_oe(hoe),
		.o_fault_flag_n_out(fo), .o_fault_flag_n_oe(foe),
		.o_thermal_warn_n_out(wo), .o_thermal_warn_n_oe(woe));
	// ************************************************************
	// tasks
	// ************************************************************
	// the extra 1 ns lets registered outputs settle before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rdchk
	// comparator levels {vref, tsd, isd, wdet, wrel}, changed on an edge
	task automatic set_env(input logic [4:0] v);
		@(posedge clk);
		{vref, thermal_shutdown_event, overcurrent_shutdown_event, wdet, wrel} <= v;
	endtask : set_env
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// hang guard, well above the six startup windows
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 15000) begin
			error_cnt++;
			final_report();
		end
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{resetn, vref, thermal_shutdown_event, overcurrent_shutdown_event, wdet, wrel, wr, rd, addr, wdata} = '0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rdchk(OFS_STATE, 32'h200);
		rdchk(OFS_IRQ_EN, 32'h0);
		rdchk(5'h1C, 32'h0);
		host_pin_model_inst.set_sel(3'h7);
		chk(hoe, 1'b1);
		chk({ho, fo, wo}, 3'h0);
		host_pin_model_inst.step(3);
		rdchk(OFS_STATE, 32'h3);
		chk(hoe, 1'b0);
		// angle 3: both phases positive, so both high sides hold
		host_pin_model_inst.set_brake(1'b1);
		chk(fs, 1'b1);
		chk(drive, 4'hA);
		host_pin_model_inst.step(1);
		chk(angle, 7'h4);
		chk(drive, 4'hA);
		host_pin_model_inst.set_brake(1'b0);
		chk(fs, 1'b0);
		set_env(5'h10);
		host_pin_model_inst.set_brake(1'b1);
		chk(drive, 4'hF);
		rdchk(OFS_STATE, 32'h7104);
		host_pin_model_inst.set_brake(1'b0);
		set_env(5'h00);
		// warning interrupt: masked sources stay quiet
		wr_reg(OFS_IRQ_EN, 32'h2);
		wr_reg(OFS_IRQ_CLR, 32'h7);
		tick(2);
		chk(irq, 1'b0);
		set_env(5'h02);
		tick(6);
		chk(woe, 1'b1);
		chk({foe, fs}, 2'h0);
		chk(irq, 1'b1);
		set_env(5'h00);
		tick(6);
		chk(woe, 1'b1);
		set_env(5'h01);
		tick(6);
		chk(woe, 1'b0);
		rdchk(OFS_STATUS, 32'h2);
		wr_reg(OFS_IRQ_CLR, 32'h2);
		tick(2);
		chk(irq, 1'b0);
		rdchk(OFS_STATUS, 32'h0);
		// thermal then overcurrent shutdown, each cleared by standby
		wr_reg(OFS_IRQ_EN, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr_reg(OFS_IRQ_CLR, 32'h7);
			set_env((i == 1) ? 5'h05 : 5'h09);
			tick(2);
			set_env(5'h01);
			tick(6);
			chk(foe, 1'b1);
			chk(drive, 4'h0);
			chk(irq, 1'b1);
			rdchk(OFS_STATUS, 32'h1);
			tick(20);
			chk(foe, 1'b1);
			chk(drive, 4'h0);
			host_pin_model_inst.set_sel(3'h0);
			chk(foe, 1'b0);
			chk(drive, 4'h0);
			host_pin_model_inst.set_sel(3'h7);
		end
		// programmed home angle, then counting down at full step
		wr_reg(OFS_HOME, 32'h5);
		rdchk(OFS_HOME, 32'h5);
		chk(hoe, 1'b0);
		host_pin_model_inst.step(5);
		chk(angle, 7'h5);
		chk(hoe, 1'b1);
		host_pin_model_inst.set_dir(1'b0);
		host_pin_model_inst.step(1);
		chk(angle, 7'h4);
		chk(hoe, 1'b0);
		host_pin_model_inst.set_sel(3'h1);
		host_pin_model_inst.step(1);
		chk(angle, 7'h64);
		chk(drive, 4'h9);
		// a supply cycle also clears a latched fault
		set_env(5'h05);
		tick(6);
		chk(foe, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		set_env(5'h01);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		tick(2);
		chk(foe, 1'b0);
		chk({drive, fs}, 5'h0);
		rdchk(OFS_HOME, 32'h0);
		final_report();
	end
endmodule : testbench
